// ---- hw/tsxo_core.sv ----
// Decode and execute of test-skip-if-zero and the two exclusive-or instructions
//
// Function
// - The test-and-skip word carries 0110011 on top, then the access bit and an 8-bit address.
// - A zero operand discards the prefetched word as a no-operation and touches no flag.
// - Test-and-skip costs one cycle, two when it skips, three when it skips a two-word one.
// - Access bit 0 picks the access bank and ignores the bank select, 1 uses the bank select.
// - The literal form has upper byte 00001010 and writes W xor literal into W in one cycle.
// - Both exclusive-or forms write only the negative and zero flags.
// - The file form has 000110 on top, then destination, access and an 8-bit address.
// - The file form computes W xor the addressed file register.
// - Destination 0 puts the result in W, destination 1 writes it back to the file register.
`timescale 1ns/100ps
module tsxo_core (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic instr_valid_i,
  input wire logic [tsxo_pkg::INSTR_W-1:0] instr_i,
  input wire logic instr_two_word_i,
  input wire logic [tsxo_pkg::BANK_W-1:0] bank_select_register_i,
  output logic [tsxo_pkg::ADDR_W-1:0] mem_rd_addr_o,
  input wire logic [tsxo_pkg::DATA_W-1:0] mem_rd_data_i,
  output logic mem_wr_en_o,
  output logic [tsxo_pkg::ADDR_W-1:0] mem_wr_addr_o,
  output logic [tsxo_pkg::DATA_W-1:0] mem_wr_data_o,
  output logic [tsxo_pkg::DATA_W-1:0] working_o,
  output logic neg_flag_o,
  output logic zero_flag_o,
  output logic flags_wr_o,
  output logic retire_o,
  output logic nop_o
);
  tsxo_pkg::tsxo_state_t st;
  tsxo_pkg::tsxo_state_t next_st;

  tsxo_alu_if alu ();

  tsxo_alu u_alu (
    .alu(alu.unit)
  );

  logic [tsxo_pkg::INSTR_W-1:0] op;
  logic is_tst;
  logic is_xlw;
  logic is_xwf;
  logic execute;
  logic [tsxo_pkg::BANK_W-1:0] bank;
  logic [tsxo_pkg::ADDR_W-1:0] f_addr;
  logic [tsxo_pkg::DATA_W-1:0] file_val;
  logic [tsxo_pkg::DATA_W-1:0] xor_val;

  // Decode of the word held in the execute stage
  always_comb begin
    op = st.ir;
    is_tst = op[tsxo_pkg::INSTR_W-1:tsxo_pkg::TST_OPC_LSB] == tsxo_pkg::TST_OPC;
    is_xlw = op[tsxo_pkg::INSTR_W-1:tsxo_pkg::XLW_OPC_LSB] == tsxo_pkg::XLW_OPC;
    is_xwf = op[tsxo_pkg::INSTR_W-1:tsxo_pkg::XWF_OPC_LSB] == tsxo_pkg::XWF_OPC;
    execute = (st.phase == tsxo_pkg::TSXO_EXEC) && st.ir_valid;
  end

  // File address: access bank or bank select
  always_comb begin
    if (op[tsxo_pkg::ACCESS_BIT]) begin
      bank = bank_select_register_i;
    end else if (op[tsxo_pkg::ACCESS_SPLIT_BIT]) begin
      bank = tsxo_pkg::ACCESS_HIGH_BANK;
    end else begin
      bank = tsxo_pkg::ACCESS_LOW_BANK;
    end
    f_addr = {bank, op[tsxo_pkg::DATA_W-1:0]};
  end

  // Pending write-back is forwarded to a read of the same address
  always_comb begin
    if (st.wr_en && (st.wr_addr == f_addr)) begin
      file_val = st.wr_data;
    end else begin
      file_val = mem_rd_data_i;
    end
  end

  // Test feeds zero xor file so the zero detect reports the operand itself
  always_comb begin
    alu.a = is_tst ? '0 : st.w;
    alu.b = is_xlw ? op[tsxo_pkg::DATA_W-1:0] : file_val;
    xor_val = alu.result;
  end

  always_comb begin
    next_st = st;
    next_st.wr_en = 1'b0;
    next_st.retire = 1'b0;
    next_st.no_operation = 1'b0;
    next_st.flags_wr = 1'b0;
    next_st.ir_valid = instr_valid_i;
    if (instr_valid_i) begin
      next_st.ir = instr_i;
      next_st.ir_two = instr_two_word_i;
    end
    unique case (st.phase)
      tsxo_pkg::TSXO_EXEC: begin
        if (st.ir_valid) begin
          next_st.retire = 1'b1;
          if (is_xlw || (is_xwf && !op[tsxo_pkg::DEST_BIT])) begin
            next_st.w = xor_val;
          end
          if (is_xwf && op[tsxo_pkg::DEST_BIT]) begin
            next_st.wr_en = 1'b1;
            next_st.wr_addr = f_addr;
            next_st.wr_data = xor_val;
          end
          if (is_xlw || is_xwf) begin
            next_st.n = alu.neg;
            next_st.z = alu.zero;
            next_st.flags_wr = 1'b1;
          end
          if (is_tst && alu.zero) begin
            next_st.phase = tsxo_pkg::TSXO_DROP;
          end
        end
      end
      tsxo_pkg::TSXO_DROP: begin
        if (st.ir_valid) begin
          next_st.no_operation = 1'b1;
          if (st.ir_two) begin
            next_st.phase = tsxo_pkg::TSXO_DROP_TAIL;
          end else begin
            next_st.phase = tsxo_pkg::TSXO_EXEC;
          end
        end
      end
      tsxo_pkg::TSXO_DROP_TAIL: begin
        if (st.ir_valid) begin
          next_st.no_operation = 1'b1;
          next_st.phase = tsxo_pkg::TSXO_EXEC;
        end
      end
      default: begin
        next_st.phase = tsxo_pkg::TSXO_EXEC;
      end
    endcase
    if (sys_rst_i) begin
      next_st = '0;
      next_st.phase = tsxo_pkg::TSXO_EXEC;
      next_st.w = tsxo_pkg::W_RESET;
      next_st.n = tsxo_pkg::FLAG_RESET;
      next_st.z = tsxo_pkg::FLAG_RESET;
    end
  end

  always_ff @(posedge clock_i) begin
    st <= next_st;
  end

  assign mem_rd_addr_o = f_addr;
  assign mem_wr_en_o = st.wr_en;
  assign mem_wr_addr_o = st.wr_addr;
  assign mem_wr_data_o = st.wr_data;
  assign working_o = st.w;
  assign neg_flag_o = st.n;
  assign zero_flag_o = st.z;
  assign flags_wr_o = st.flags_wr;
  assign retire_o = st.retire;
  assign nop_o = st.no_operation;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_tst_zero;
    execute && is_tst && alu.zero;
  endsequence

  sequence s_two_word_next;
    st.ir_valid && st.ir_two;
  endsequence

  decode_onehot_a: assert property (
    is_tst |-> !is_xlw && !is_xwf)
    else $error("test-skip decode overlaps another opcode");

  skip_enter_a: assert property (
    s_tst_zero |=> st.phase == tsxo_pkg::TSXO_DROP)
    else $error("zero operand did not start a skip");

  tst_flags_keep_a: assert property (
    execute && is_tst |=> $stable(neg_flag_o) && $stable(zero_flag_o) && !mem_wr_en_o
      && !flags_wr_o && $stable(working_o))
    else $error("test-skip changed state");

  drop_nop_a: assert property (
    st.phase == tsxo_pkg::TSXO_DROP && st.ir_valid |=> nop_o && !retire_o
      && $stable(working_o) && !mem_wr_en_o)
    else $error("prefetched word was not discarded");

  no_skip_a: assert property (
    execute && is_tst && !alu.zero |=> st.phase == tsxo_pkg::TSXO_EXEC)
    else $error("nonzero operand caused a skip");

  skip_two_a: assert property (
    s_tst_zero ##1 s_two_word_next |=> st.phase == tsxo_pkg::TSXO_DROP_TAIL && nop_o)
    else $error("two-word skip did not enter the tail drop");

  tail_drop_a: assert property (
    st.phase == tsxo_pkg::TSXO_DROP_TAIL && st.ir_valid |=> st.phase == tsxo_pkg::TSXO_EXEC
      && nop_o && !retire_o && !mem_wr_en_o && !flags_wr_o)
    else $error("second word of a skipped pair was not discarded");

  skip_one_a: assert property (
    s_tst_zero ##1 (st.ir_valid && !st.ir_two) |=> st.phase == tsxo_pkg::TSXO_EXEC && nop_o)
    else $error("single-word skip took the wrong length");

  bank_access_a: assert property (
    !op[tsxo_pkg::ACCESS_BIT] |-> f_addr[tsxo_pkg::ADDR_W-1:tsxo_pkg::DATA_W]
      == (op[tsxo_pkg::ACCESS_SPLIT_BIT] ? tsxo_pkg::ACCESS_HIGH_BANK
      : tsxo_pkg::ACCESS_LOW_BANK))
    else $error("access bank address wrong");

  bank_select_a: assert property (
    op[tsxo_pkg::ACCESS_BIT] |-> f_addr[tsxo_pkg::ADDR_W-1:tsxo_pkg::DATA_W]
      == bank_select_register_i)
    else $error("bank select not used");

  literal_xor_a: assert property (
    execute && is_xlw |=> working_o == ($past(st.w) ^ $past(op[7:0])) && retire_o)
    else $error("literal xor result wrong");

  file_to_w_a: assert property (
    execute && is_xwf && !op[tsxo_pkg::DEST_BIT] |=> working_o == $past(xor_val)
      && !mem_wr_en_o && retire_o)
    else $error("file xor into W wrong");

  file_to_f_a: assert property (
    execute && is_xwf && op[tsxo_pkg::DEST_BIT] |=> mem_wr_en_o
      && mem_wr_addr_o == $past(f_addr) && mem_wr_data_o == $past(xor_val)
      && $stable(working_o) && retire_o)
    else $error("file xor write-back wrong");

  nz_flags_a: assert property (
    execute && (is_xlw || is_xwf) |=> flags_wr_o && neg_flag_o == $past(xor_val[7])
      && zero_flag_o == ($past(xor_val) == 8'h00))
    else $error("negative or zero flag wrong");

endmodule

// ---- hw/tsxo_pkg.sv ----
// Constants and types shared by the test-skip and exclusive-or execution block
package tsxo_pkg;

  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int ADDR_W = BANK_W + DATA_W;
  localparam int INSTR_W = 16;

  // Opcode fields
  localparam int TST_OPC_LSB = 9;
  localparam logic [6:0] TST_OPC = 7'h33;
  localparam int XLW_OPC_LSB = 8;
  localparam logic [7:0] XLW_OPC = 8'h0a;
  localparam int XWF_OPC_LSB = 10;
  localparam logic [5:0] XWF_OPC = 6'h06;

  // Operand field positions
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int ACCESS_SPLIT_BIT = 7;

  // Banks reached through the access bank
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

  // Reset values
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic [1:0] {
    TSXO_EXEC,
    TSXO_DROP,
    TSXO_DROP_TAIL
  } tsxo_phase_t;

  typedef struct packed {
    tsxo_phase_t phase;
    logic ir_valid;
    logic ir_two;
    logic [INSTR_W-1:0] ir;
    logic [DATA_W-1:0] w;
    logic n;
    logic z;
    logic flags_wr;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic retire;
    logic no_operation;
  } tsxo_state_t;

endpackage

// ---- hw/tsxo_alu_if.sv ----
// Operand and result bundle between the sequencer and the exclusive-or unit
`timescale 1ns/100ps
interface tsxo_alu_if;
  logic [tsxo_pkg::DATA_W-1:0] a;
  logic [tsxo_pkg::DATA_W-1:0] b;
  logic [tsxo_pkg::DATA_W-1:0] result;
  logic neg;
  logic zero;

  modport user (output a, output b, input result, input neg, input zero);
  modport unit (input a, input b, output result, output neg, output zero);
endinterface

// ---- hw/tsxo_alu.sv ----
// Exclusive-or unit with negative and zero detection
`timescale 1ns/100ps
module tsxo_alu (
  tsxo_alu_if.unit alu
);
  always_comb begin
    alu.result = alu.a ^ alu.b;
    alu.neg = alu.result[tsxo_pkg::DATA_W-1];
    alu.zero = ~|alu.result;
  end
endmodule

// ---- testbench/tsxo_mem_model.sv ----
// Data memory model with combinational read and registered write
`timescale 1ns/100ps
module tsxo_mem_model (
  input wire logic clock_i,
  input wire logic [tsxo_pkg::ADDR_W-1:0] rd_addr_i,
  output logic [tsxo_pkg::DATA_W-1:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [tsxo_pkg::ADDR_W-1:0] wr_addr_i,
  input wire logic [tsxo_pkg::DATA_W-1:0] wr_data_i
);
  logic [tsxo_pkg::DATA_W-1:0] mem [0:(1<<tsxo_pkg::ADDR_W)-1];

  // Zero at every offset 0 of a bank, so skips happen
  initial begin
    for (int a = 0; a < (1 << tsxo_pkg::ADDR_W); a++) begin
      mem[a] = 8'(a * 8'h25);
    end
  end

  assign rd_data_o = mem[rd_addr_i];

  always @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule

// ---- testbench/test_test_skip_and_xor_ops.sv ----
// Self-checking bench for the test-skip and exclusive-or execution block
`timescale 1ns/100ps
module test_test_skip_and_xor_ops;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic instr_two_word_i = 1'b0;
  logic [3:0] bank_select_register_i = 4'h0;
  logic [11:0] mem_rd_addr_o, mem_wr_addr_o, e_wa, ea;
  logic [7:0] mem_rd_data_i, mem_wr_data_o, working_o, e_w, e_wd, res;
  logic mem_wr_en_o, neg_flag_o, zero_flag_o, flags_wr_o, retire_o, nop_o;
  logic e_n, e_z, e_fw, e_wr, e_ret, e_nop, ex_v, ex_two;
  logic chk_on = 1'b0;
  logic [15:0] ex_w;
  logic [7:0] shadow [0:4095];
  int sk;
  int err_count = 0;
  int comparisons = 0;

  always #2 clock_i = ~clock_i;

  tsxo_core u_tsxo_core (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_two_word_i(instr_two_word_i),
    .bank_select_register_i(bank_select_register_i), .mem_rd_addr_o(mem_rd_addr_o),
    .mem_rd_data_i(mem_rd_data_i), .mem_wr_en_o(mem_wr_en_o), .mem_wr_addr_o(mem_wr_addr_o),
    .mem_wr_data_o(mem_wr_data_o), .working_o(working_o), .neg_flag_o(neg_flag_o),
    .zero_flag_o(zero_flag_o), .flags_wr_o(flags_wr_o), .retire_o(retire_o), .nop_o(nop_o));

  tsxo_mem_model u_tsxo_mem_model (.clock_i(clock_i), .rd_addr_i(mem_rd_addr_o),
    .rd_data_o(mem_rd_data_i), .wr_en_i(mem_wr_en_o), .wr_addr_i(mem_wr_addr_o),
    .wr_data_i(mem_wr_data_o));

  function automatic logic [11:0] eff_addr(logic [15:0] w, logic [3:0] bank_select_register);
    if (w[8]) begin
      return {bank_select_register, w[7:0]};
    end
    return {w[7] ? 4'hf : 4'h0, w[7:0]};
  endfunction

  // Reference pipeline: word taken at one edge shows its effect at the next edge
  always @(posedge clock_i) begin
    {e_fw, e_wr, e_ret, e_nop} = 4'h0;
    if (sys_rst_i) begin
      {e_w, e_n, e_z, ex_v} = 11'h000;
      sk = 0;
    end else begin
      if (ex_v && sk != 0) begin
        e_nop = 1'b1;
        sk = (sk == 1 && ex_two) ? 2 : 0;
      end else if (ex_v) begin
        e_ret = 1'b1;
        ea = eff_addr(ex_w, bank_select_register_i);
        if (ex_w[15:9] == 7'h33) begin
          sk = (shadow[ea] == 8'h00) ? 1 : 0;
        end else if (ex_w[15:8] == 8'h0a || ex_w[15:10] == 6'h06) begin
          res = e_w ^ (ex_w[12] ? shadow[ea] : ex_w[7:0]);
          e_fw = 1'b1;
          e_n = res[7];
          e_z = (res == 8'h00);
          if (ex_w[12] && ex_w[9]) begin
            {e_wr, e_wa, e_wd} = {1'b1, ea, res};
            shadow[ea] = res;
          end else begin
            e_w = res;
          end
        end
      end
      {ex_v, ex_w, ex_two} = {instr_valid_i, instr_i, instr_two_word_i};
    end
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  always @(negedge clock_i) begin
    if (chk_on) begin
      check(12'(retire_o), 12'(e_ret));
      check(12'(nop_o), 12'(e_nop));
      check(12'(flags_wr_o), 12'(e_fw));
      check(12'(working_o), 12'(e_w));
      check(12'(neg_flag_o), 12'(e_n));
      check(12'(zero_flag_o), 12'(e_z));
      check(12'(mem_wr_en_o), 12'(e_wr));
      if (e_wr) begin
        check(mem_wr_addr_o, e_wa);
        check(12'(mem_wr_data_o), 12'(e_wd));
      end
    end
  end

  task automatic put(input int v, input logic [15:0] w, input int two);
    @(negedge clock_i);
    instr_valid_i = v[0];
    instr_i = w;
    instr_two_word_i = two[0];
    bank_select_register_i = 4'($urandom);
  endtask

  function automatic logic [7:0] pick_f();
    case ($urandom % 4)
      0: return 8'h00;
      1: return 8'h80;
      2: return 8'h01;
      default: return 8'($urandom);
    endcase
  endfunction

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(84421));
    for (int a = 0; a < 4096; a++) begin
      shadow[a] = 8'(a * 8'h25);
    end
    repeat (12) @(posedge clock_i);
    chk_on = 1'b1;
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    // Skip over a two-word pair, then over a gap
    put(1, {7'h33, 1'b0, 8'h00}, 0);
    put(1, {4'hc, 12'h123}, 1);
    put(1, {4'hf, 12'h456}, 0);
    put(1, {8'h0a, 8'h80}, 0);
    put(1, {7'h33, 1'b0, 8'h80}, 0);
    put(1, {7'h33, 1'b0, 8'h00}, 0);
    put(0, 16'h0a55, 0);
    put(0, 16'h0a55, 0);
    put(1, {8'h0a, 8'h3c}, 0);
    put(1, {6'h06, 2'b10, 8'h81}, 0);
    put(1, {6'h06, 2'b10, 8'h81}, 0);
    put(1, {7'h33, 1'b0, 8'h81}, 0);
    put(0, 16'h0000, 0);
    put(0, 16'h0000, 0);
    put(1, {8'h0a, e_w}, 0);
    for (int i = 0; i < 3000; i++) begin
      if (i == 1500) begin
        @(negedge clock_i);
        sys_rst_i = 1'b1;
        put(1, {8'h0a, 8'hff}, 0);
        sys_rst_i = 1'b0;
      end
      case ($urandom % 6)
        0: put(1, {7'h33, 1'($urandom), pick_f()}, 0);
        1: put(1, {8'h0a, 8'($urandom)}, 0);
        2, 3: put(1, {6'h06, 2'($urandom), pick_f()}, 0);
        4: begin
          put(1, {4'hc, 12'($urandom)}, 1);
          put(1, {4'hf, 12'($urandom)}, 0);
        end
        default: put(0, 16'($urandom), 0);
      endcase
    end
    repeat (4) put(0, 16'h0000, 0);
    conclude();
  end
endmodule
